// File: src/ppdc_top.sv
// Pad pull-up and high-drive control register bank
`timescale 1ns/1ps
`default_nettype none
module ppdc_top
  import ppdc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              core_clk,          // 50 MHz clock
  input  wire logic              sys_rst,           // Sync reset, high
  input  wire logic [ADDR_W-1:0] reg_addr,          // Byte address
  input  wire logic [31:0]       reg_wdata,         // Write data
  input  wire logic              reg_wr,            // Write strobe
  input  wire logic              reg_rd,            // Read strobe
  output logic      [31:0]       reg_rdata,         // Read data, next cycle
  input  wire logic [7:0]        pa_out_en,         // first_port pin is output
  input  wire logic [7:0]        pa_in_en,          // first_port pin is input
  input  wire logic [7:0]        pa_out_val,        // first_port driven level
  input  wire logic              pa_twb_en,         // Pins 2,3 used by two_wire_bus
  input  wire logic [7:0]        pb_in_en,          // second_port pin is input
  output logic      [7:0]        pa_pullup,         // first_port pull-up to pads
  output logic      [7:0]        pb_pullup,         // second_port pull-up to pads
  output logic                   portc_pin5_drive,  // High drive third_port pin 5
  output logic                   portc_pin1_drive,  // High drive third_port pin 1
  output logic                   portb_pin5_drive   // High drive second_port pin 5
);

  // Elaboration checks on address width and bit map
  if (ADDR_W < 4 || ADDR_W > 8) begin : g_bad_addr_w
    $error("ppdc_top: ADDR_W must be 4..8");
  end
  if (PPDC_PULL_ENABLE_LOW_OFS == PPDC_HIGH_DRIVE_ENABLE_OFS) begin : g_bad_offsets
    $error("ppdc_top: register offsets must differ");
  end
  if (PPDC_PC5_DRV_BIT != PPDC_PB5_DRV_BIT + 2) begin : g_bad_pc5_bit
    $error("ppdc_top: drive fields must be contiguous");
  end
  if (PPDC_PC1_DRV_BIT != PPDC_PB5_DRV_BIT + 1) begin : g_bad_pc1_bit
    $error("ppdc_top: drive fields must be contiguous");
  end
  if (PPDC_TWB_SDA_PIN > PPDC_TWB_SCL_PIN || PPDC_TWB_SCL_PIN > 7) begin : g_bad_twb_pins
    $error("ppdc_top: two_wire_bus pins out of range");
  end
  if (PPDC_PA_LSB + 8 > PPDC_PB_LSB) begin : g_bad_pa_field
    $error("ppdc_top: pull fields overlap");
  end
  if (PPDC_PB_LSB + 8 > 16) begin : g_bad_pb_field
    $error("ppdc_top: pull field beyond register");
  end

  logic [15:0] pull_enable_low;
  logic [2:0]  high_drive_enable;
  logic [7:0]  pa_in_q2;
  logic [7:0]  pa_out_q2;
  logic [7:0]  pa_val_q2;
  logic [7:0]  pb_in_q2;
  logic        twb_q2;
  logic [7:0]  next_pa_pullup;
  logic [31:0] next_rdata;

  wire logic [7:0] sel_addr = 8'(reg_addr);
  wire logic hit_pull  = (sel_addr == PPDC_PULL_ENABLE_LOW_OFS);
  wire logic hit_drive = (sel_addr == PPDC_HIGH_DRIVE_ENABLE_OFS);

  // Pull enable register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pull_enable_low <= PPDC_PULL_RESET;
    end else if (reg_wr && hit_pull) begin
      pull_enable_low <= reg_wdata[15:0];
    end
  end

  // High drive register, reserved bits dropped
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      high_drive_enable <= PPDC_DRIVE_RESET;
    end else if (reg_wr && hit_drive) begin
      high_drive_enable <= reg_wdata[PPDC_PC5_DRV_BIT:PPDC_PB5_DRV_BIT];
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_pull) begin
      next_rdata[15:0] = pull_enable_low;
    end else if (hit_drive) begin
      next_rdata[PPDC_PC5_DRV_BIT:PPDC_PB5_DRV_BIT] = high_drive_enable;
    end
  end

  // Read data valid only the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // Pin state synchronisers
  ppdc_sync2 #(
    .WIDTH (8)
  ) pa_in_sync_u (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (pa_in_en),
    .sync_out (pa_in_q2)
  );

  ppdc_sync2 #(
    .WIDTH (8)
  ) pa_out_sync_u (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (pa_out_en),
    .sync_out (pa_out_q2)
  );

  ppdc_sync2 #(
    .WIDTH (8)
  ) pa_val_sync_u (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (pa_out_val),
    .sync_out (pa_val_q2)
  );

  ppdc_sync2 #(
    .WIDTH (8)
  ) pb_in_sync_u (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (pb_in_en),
    .sync_out (pb_in_q2)
  );

  ppdc_sync2 #(
    .WIDTH (1)
  ) twb_sync_u (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (pa_twb_en),
    .sync_out (twb_q2)
  );

  always_comb begin
    next_pa_pullup = pull_enable_low[PPDC_PA_LSB +: 8] & pa_in_q2 & ~pa_out_q2;
    if (twb_q2) begin
      for (int i = PPDC_TWB_SDA_PIN; i <= PPDC_TWB_SCL_PIN; i++) begin
        if (pa_out_q2[i]) begin
          next_pa_pullup[i] = pull_enable_low[PPDC_PA_LSB + i] & pa_val_q2[i];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pa_pullup <= 8'h00;
    end else begin
      pa_pullup <= next_pa_pullup;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pb_pullup <= 8'h00;
    end else begin
      pb_pullup <= pull_enable_low[PPDC_PB_LSB +: 8] & pb_in_q2;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      portc_pin5_drive <= 1'b0;
    end else begin
      portc_pin5_drive <= high_drive_enable[PPDC_PC5_DRV_BIT - PPDC_PB5_DRV_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      portc_pin1_drive <= 1'b0;
    end else begin
      portc_pin1_drive <= high_drive_enable[PPDC_PC1_DRV_BIT - PPDC_PB5_DRV_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      portb_pin5_drive <= 1'b0;
    end else begin
      portb_pin5_drive <= high_drive_enable[0];
    end
  end

  // Assertions
  logic past_valid;
  always_ff @(posedge core_clk) begin
    if (sys_rst) past_valid <= 1'b0;
    else past_valid <= 1'b1;
  end

  sequence drive_write_s;
    reg_wr && hit_drive;
  endsequence

  sequence pull_write_s;
    reg_wr && hit_pull;
  endsequence

  sequence pull_read_s;
    reg_rd && hit_pull && !reg_wr;
  endsequence

  sequence drive_read_s;
    reg_rd && hit_drive;
  endsequence

  pull_readback_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_wr && hit_pull ##1 reg_rd && hit_pull && !reg_wr |=> reg_rdata[15:0] == $past(reg_wdata[15:0], 2))
    else $error("pull register readback wrong");
  drive_reserved_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_rd && hit_drive |=> reg_rdata[31:4] == 28'h0 && reg_rdata[0] == 1'b0)
    else $error("reserved drive bits not zero");
  pc5_drive_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    drive_write_s |-> ##2 portc_pin5_drive == $past(reg_wdata[3], 2))
    else $error("third_port pin 5 drive wrong");
  pc1_drive_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    drive_write_s |-> ##2 portc_pin1_drive == $past(reg_wdata[2], 2))
    else $error("third_port pin 1 drive wrong");
  pb5_drive_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    drive_write_s |-> ##2 portb_pin5_drive == $past(reg_wdata[1], 2))
    else $error("second_port pin 5 drive wrong");
  out_no_pull_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    past_valid && !twb_q2 |=> (pa_pullup & $past(pa_out_q2)) == 8'h00)
    else $error("pull-up on output pin");
  twb_low_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    twb_q2 && pa_out_q2[2] && !pa_val_q2[2] |=> !pa_pullup[2])
    else $error("pull-up kept while driving low");
  twb_high_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    twb_q2 && pa_out_q2[3] && pa_val_q2[3] |=> pa_pullup[3] == $past(pull_enable_low[3]))
    else $error("pull-up wrong while driving high");
  pb_pull_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    past_valid |=> pb_pullup == ($past(pull_enable_low[15:8]) & $past(pb_in_q2)))
    else $error("second_port pull-up wrong");
  input_pull_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    past_valid && pa_in_q2[0] && !pa_out_q2[0] |=> pa_pullup[0] == $past(pull_enable_low[0]))
    else $error("first_port pin 0 pull-up wrong");

  // Register bus checks
  rdata_idle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside read");
  unmapped_read_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    reg_rd && !hit_pull && !hit_drive |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  pull_upper_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    pull_read_s |=> reg_rdata[31:16] == 16'h0000)
    else $error("pull register upper bits not zero");
  pull_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    pull_write_s |=> pull_enable_low == $past(reg_wdata[15:0]))
    else $error("pull register write lost");
  pull_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !(reg_wr && hit_pull) |=> $stable(pull_enable_low))
    else $error("pull register changed without write");
  drive_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    drive_write_s |=> high_drive_enable == $past(reg_wdata[PPDC_PC5_DRV_BIT:PPDC_PB5_DRV_BIT]))
    else $error("drive register write lost");
  drive_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !(reg_wr && hit_drive) |=> $stable(high_drive_enable))
    else $error("drive register changed without write");
  drive_readback_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    drive_read_s |=> reg_rdata[PPDC_PC5_DRV_BIT:PPDC_PB5_DRV_BIT] == $past(high_drive_enable))
    else $error("drive register readback wrong");

  // Pad pull-up checks
  pa_plain_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    past_valid && !twb_q2 |=> pa_pullup == $past(pull_enable_low[7:0] & pa_in_q2 & ~pa_out_q2))
    else $error("first_port pull-up wrong");
  hiz_no_pull_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    past_valid |=> (pa_pullup & $past(~pa_in_q2 & ~pa_out_q2)) == 8'h00)
    else $error("pull-up on high-impedance pin");
  pb_hiz_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    past_valid |=> (pb_pullup & ~$past(pb_in_q2)) == 8'h00)
    else $error("second_port pull-up on non-input pin");
  twb_low_scl_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    twb_q2 && pa_out_q2[3] && !pa_val_q2[3] |=> !pa_pullup[3])
    else $error("pull-up kept while pin 3 drives low");
  twb_high_sda_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    twb_q2 && pa_out_q2[2] && pa_val_q2[2] |=> pa_pullup[2] == $past(pull_enable_low[2]))
    else $error("pull-up wrong while pin 2 drives high");
  twb_input_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    twb_q2 && !pa_out_q2[2] |=> pa_pullup[2] == $past(pull_enable_low[2] & pa_in_q2[2]))
    else $error("two_wire_bus pin 2 input pull-up wrong");
  twb_other_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    twb_q2 |=> pa_pullup[1:0] == $past(pull_enable_low[1:0] & pa_in_q2[1:0] & ~pa_out_q2[1:0])
      && pa_pullup[7:4] == $past(pull_enable_low[7:4] & pa_in_q2[7:4] & ~pa_out_q2[7:4]))
    else $error("pull-up wrong on pins outside two_wire_bus");

  // Drive output checks
  reset_drive_a: assert property (@(posedge core_clk)
    sys_rst |=> !portc_pin5_drive && !portc_pin1_drive && !portb_pin5_drive)
    else $error("high drive active after reset");
  pc5_follow_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    past_valid |=> portc_pin5_drive == $past(high_drive_enable[2]))
    else $error("third_port pin 5 drive not from register");
  pc1_follow_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    past_valid |=> portc_pin1_drive == $past(high_drive_enable[1]))
    else $error("third_port pin 1 drive not from register");
  pb5_follow_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    past_valid |=> portb_pin5_drive == $past(high_drive_enable[0]))
    else $error("second_port pin 5 drive not from register");

endmodule

// Two-flop synchroniser for pad configuration levels
module ppdc_sync2
  import ppdc_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk,  // Block clock
  input  wire logic             sys_rst,   // Sync reset, high
  input  wire logic [WIDTH-1:0] async_in,  // Level from outside the domain
  output logic      [WIDTH-1:0] sync_out   // Level after two flops
);

  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1) begin : g_bad_width
    $error("ppdc_sync2: WIDTH must be at least 1");
  end

  // Only the second flop is read outside
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_q   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

// File: src/ppdc_pkg.sv
// Package with register map, field positions and reset values for pad pull-up and drive control
// Notes on behaviour
// - Bit n enables pull-up on first_port pin n
// - Pull-up acts only on input pins, save two-wire pins driving high
// - Two-wire pins driving high keep enabled pull-up
// - Two-wire pins driving low drop pull-up
// - High-drive enable register sits at offset 0xc
// - High-drive bits 31-4 and 0 read zero
// - Bit 3 gives third_port pin 5 high drive
// - Bit 2 gives third_port pin 1 high drive
// - Bit 1 gives second_port pin 5 high drive
// - Bits 15-8 enable second_port pull-ups
package ppdc_pkg;
  localparam logic [7:0]  PPDC_PULL_ENABLE_LOW_OFS  = 8'h08;
  localparam logic [7:0]  PPDC_HIGH_DRIVE_ENABLE_OFS = 8'h0c;
  localparam int          PPDC_PA_LSB        = 0;
  localparam int          PPDC_PB_LSB        = 8;
  localparam int          PPDC_PC5_DRV_BIT   = 3;
  localparam int          PPDC_PC1_DRV_BIT   = 2;
  localparam int          PPDC_PB5_DRV_BIT   = 1;
  localparam int          PPDC_TWB_SDA_PIN   = 2;
  localparam int          PPDC_TWB_SCL_PIN   = 3;
  localparam logic [15:0] PPDC_PULL_RESET    = 16'h0000;
  localparam logic [2:0]  PPDC_DRIVE_RESET   = 3'h0;
endpackage

// File: tb/test_pad_pullup_drive_control.sv
// Testbench for the pad pull-up and high-drive register bank
`timescale 1ns/1ps
`default_nettype none
module test_pad_pullup_drive_control;
  import ppdc_pkg::*;
  logic        core_clk, sys_rst, reg_wr, reg_rd, pa_twb_en;
  logic [7:0]  reg_addr, pa_out_en, pa_in_en, pa_out_val, pb_in_en, pa_pullup, pb_pullup;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  logic        portc_pin5_drive, portc_pin1_drive, portb_pin5_drive;
  int          n_fail, checks_done;

  ppdc_top dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pa_out_en(pa_out_en), .pa_in_en(pa_in_en),
    .pa_out_val(pa_out_val), .pa_twb_en(pa_twb_en), .pb_in_en(pb_in_en), .pa_pullup(pa_pullup),
    .pb_pullup(pb_pullup), .portc_pin5_drive(portc_pin5_drive), .portc_pin1_drive(portc_pin1_drive),
    .portb_pin5_drive(portb_pin5_drive));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic test_done();
    if (n_fail == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  // Pin settings pass two sync flops and an output flop
  task automatic pins(input logic [7:0] oe, ie, ov, input logic twb, input logic [7:0] pbie,
                      input logic [15:0] exp);
    @(posedge core_clk);
    pa_out_en <= oe; pa_in_en <= ie; pa_out_val <= ov; pa_twb_en <= twb; pb_in_en <= pbie;
    repeat (4) @(posedge core_clk);
    #1 chk({16'h0, pb_pullup, pa_pullup}, {16'h0, exp});
  endtask

  function automatic logic [31:0] drv();
    return {29'h0, portc_pin5_drive, portc_pin1_drive, portb_pin5_drive};
  endfunction

  initial begin
    n_fail = 0; checks_done = 0;
    sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
    pa_out_en = 8'h00; pa_in_en = 8'hff; pa_out_val = 8'h00; pa_twb_en = 1'b0; pb_in_en = 8'hff;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(PPDC_HIGH_DRIVE_ENABLE_OFS); chk(rd_val, 32'h0);
    rd(PPDC_PULL_ENABLE_LOW_OFS); chk(rd_val, 32'h0);
    wr(PPDC_HIGH_DRIVE_ENABLE_OFS, 32'hffffffff);
    rd(PPDC_HIGH_DRIVE_ENABLE_OFS); chk(rd_val, 32'h0000000e);
    chk(drv(), 32'h7);
    wr(PPDC_HIGH_DRIVE_ENABLE_OFS, 32'h00000005);
    rd(PPDC_HIGH_DRIVE_ENABLE_OFS); chk(rd_val, 32'h00000004);
    chk(drv(), 32'h2);
    wr(PPDC_HIGH_DRIVE_ENABLE_OFS, 32'h0000000a);
    wr(8'h10, 32'hffffffff);
    rd(8'h10); chk(rd_val, 32'h0);
    rd(PPDC_HIGH_DRIVE_ENABLE_OFS); chk(rd_val, 32'h0000000a);
    chk(drv(), 32'h5);
    wr(PPDC_PULL_ENABLE_LOW_OFS, 32'h00005aa5);
    rd(PPDC_PULL_ENABLE_LOW_OFS); chk(rd_val, 32'h00005aa5);
    pins(8'h00, 8'hff, 8'h00, 1'b0, 8'hff, 16'h5aa5);
    pins(8'hff, 8'h00, 8'hff, 1'b0, 8'h0f, 16'h0a00);
    pins(8'h00, 8'h00, 8'h00, 1'b0, 8'h00, 16'h0000);
    wr(PPDC_PULL_ENABLE_LOW_OFS, 32'h000000ff);
    pins(8'h0c, 8'hf3, 8'h04, 1'b1, 8'h00, 16'h00f7);
    pins(8'h0c, 8'hf3, 8'h08, 1'b1, 8'h00, 16'h00fb);
    pins(8'h0c, 8'hf3, 8'h0c, 1'b0, 8'h00, 16'h00f3);
    // Write then read with no gap, then read data falls back to zero
    @(posedge core_clk);
    reg_wr <= 1'b1; reg_addr <= PPDC_PULL_ENABLE_LOW_OFS; reg_wdata <= 32'h0000c33c;
    @(posedge core_clk);
    reg_wr <= 1'b0; reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, 32'h0000c33c);
    @(posedge core_clk);
    #1 chk(reg_rdata, 32'h0);
    test_done();
  end

  initial begin
    repeat (2000) @(posedge core_clk);
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire
